// >>> core/thermal_alarm_status.sv
// top of the second and third alarm status logic
// assumes conversion results, limits, hysteresis and masks come from
// logic on the same clock; the two-wire slave supplies decoded reads
`timescale 1ns/1ns
module thermal_alarm_status
    import thermal_alarm_pkg::*;
#(
    parameter int TEMP_W = 11
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,

    // conversion results, one store strobe per channel
    input  wire ch_flags_s                result_stored,
    input  wire logic signed [TEMP_W-1:0] local_reading,
    input  wire logic signed [TEMP_W-1:0] ch1_reading,
    input  wire logic signed [TEMP_W-1:0] ch2_reading,
    input  wire logic signed [TEMP_W-1:0] ch3_reading,
    input  wire logic signed [TEMP_W-1:0] ch4_reading,

    // alarm limits and shared hysteresis
    input  wire logic signed [TEMP_W-1:0] local_limit,
    input  wire logic signed [TEMP_W-1:0] ch1_limit_b,
    input  wire logic signed [TEMP_W-1:0] ch2_limit_b,
    input  wire logic signed [TEMP_W-1:0] ch3_limit,
    input  wire logic signed [TEMP_W-1:0] ch4_limit,
    input  wire logic [TEMP_W-1:0]        shared_hyst,

    // mask register contents, one means blocked
    input  wire ch_flags_s                mask_b,
    input  wire ch_flags_s                mask_c,

    // sensor model detection per remote channel, bit 0 = remote 1
    input  wire logic [3:0]               beta_comp_on,
    input  wire logic [3:0]               small_bjt_seen,

    // register reads from the two-wire slave
    input  wire rd_req_s                  rd_req,
    output rd_rsp_s                       rd_rsp,

    // summary flags for the main status register
    output logic                          alarm_b_summary_flag,
    output logic                          alarm_c_summary_flag,

    // alarm pins, active low
    output logic                          second_alarm_out_n,
    output logic                          third_alarm_out_n
);

    // refuse widths the comparator cannot serve
    if (TEMP_W < 2 || TEMP_W > 16) begin : g_width_check
        $error("thermal_alarm_status: TEMP_W must lie in 2..16");
    end

    // per-channel comparison inputs gathered for the generate loop
    logic signed [TEMP_W-1:0] reading [NUM_CH];
    logic signed [TEMP_W-1:0] limit   [NUM_CH];
    logic [NUM_CH-1:0]        update;
    logic [NUM_CH-1:0]        hit;

    // channel-to-limit routing; both status registers share these limits
    assign reading[LOCAL_BIT] = local_reading;
    assign reading[CH1_BIT]   = ch1_reading;
    assign reading[CH2_BIT]   = ch2_reading;
    assign reading[CH3_BIT]   = ch3_reading;
    assign reading[CH4_BIT]   = ch4_reading;
    assign limit[LOCAL_BIT]   = local_limit;
    assign limit[CH1_BIT]     = ch1_limit_b;
    assign limit[CH2_BIT]     = ch2_limit_b;
    assign limit[CH3_BIT]     = ch3_limit;
    assign limit[CH4_BIT]     = ch4_limit;
    assign update             = result_stored;

    // one comparator per channel; the flag feeds both registers because
    // the limits are identical, which saves five comparators
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        alarm_hyst_cmp #(
            .TEMP_W (TEMP_W)
        ) u_cmp (
            .clk     (clk),
            .rst_n   (rst_n),
            .update  (update[i]),
            .reading (reading[i]),
            .limit   (limit[i]),
            .hyst    (shared_hyst),
            .flag    (hit[i])
        );
    end

    // named flags in status layout
    ch_flags_s alarm_b;
    ch_flags_s alarm_c;
    assign alarm_b = ch_flags_s'(hit);
    assign alarm_c = ch_flags_s'(hit);

    // status register images; reserved high bits read zero
    logic [7:0] second_alarm_status;
    logic [7:0] third_alarm_status;
    assign second_alarm_status = {3'b000, alarm_b};
    assign third_alarm_status  = {3'b000, alarm_c};

    // masked alarm terms
    logic any_b_unmasked;
    logic any_c_unmasked;
    assign any_b_unmasked = |(alarm_b & ~mask_b);
    assign any_c_unmasked = |(alarm_c & ~mask_c);

    // model status: bit 0 and bits 7..5 stay zero
    logic [7:0] next_model;
    assign next_model = {3'b000, beta_comp_on & small_bjt_seen, 1'b0};

    logic [7:0] sensor_model_status;

    // pins and summaries are registered so they never glitch on the board;
    // they follow the flags with one cycle of delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            second_alarm_out_n   <= 1'b1;
            third_alarm_out_n    <= 1'b1;
            alarm_b_summary_flag <= 1'b0;
            alarm_c_summary_flag <= 1'b0;
        end else begin
            second_alarm_out_n   <= ~any_b_unmasked;
            third_alarm_out_n    <= ~any_c_unmasked;
            alarm_b_summary_flag <= |second_alarm_status;
            alarm_c_summary_flag <= |third_alarm_status;
        end
    end

    // model status tracks detection continuously
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sensor_model_status <= STATUS_RESET;
        end else begin
            sensor_model_status <= next_model;
        end
    end

    // command-byte read port
    status_read_port u_rd (
        .clk                 (clk),
        .rst_n               (rst_n),
        .second_alarm_status (second_alarm_status),
        .third_alarm_status  (third_alarm_status),
        .sensor_model_status (sensor_model_status),
        .rd_req              (rd_req),
        .rd_rsp              (rd_rsp)
    );

endmodule

// >>> core/thermal_alarm_pkg.sv
// constants, field layouts and carrier types for the alarm status block
// assumes one 100 MHz clock shared with the conversion engine and command port
//
// Overview of operation
// - second alarm pin low while any unmasked second-status bit is set
// - third alarm pin low while any unmasked third-status bit is set
// - a channel flag sets when reading is at or above its limit
// - flag clears only below limit minus shared hysteresis; holds in between
// - remote channel 2 uses its second limit in both status registers
// - remote channel 1 uses its second limit; local uses its only limit
// - remote 3 and 4 use one limit each; bits 3 and 4
// - local bit 0, remote 1 bit 1, remote 2 bit 2; bits 7..5 zero
// - model status bits 4..1 = beta comp on and small transistor seen; bit 0 zero
// - summary flags mirror whether each status register has any bit set
// - a mask bit of one blocks that channel from its alarm pin
package thermal_alarm_pkg;

    // command byte offsets of the registers served here
    localparam logic [7:0] SECOND_ALARM_STATUS_OFS = 8'h09;
    localparam logic [7:0] THIRD_ALARM_STATUS_OFS  = 8'h0a;
    localparam logic [7:0] SENSOR_MODEL_STATUS_OFS = 8'h38;

    // channel count and bit positions inside the status registers
    localparam int NUM_CH       = 5;
    localparam int LOCAL_BIT    = 0;
    localparam int CH1_BIT      = 1;
    localparam int CH2_BIT      = 2;
    localparam int CH3_BIT      = 3;
    localparam int CH4_BIT      = 4;
    localparam int MODEL_LO_BIT = 1;

    // reset value and value read for unmapped commands
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;

    // one flag per channel, bit order matches the status layout
    typedef struct packed {
        logic ch4;
        logic ch3;
        logic ch2;
        logic ch1;
        logic local_ch;
    } ch_flags_s;

    // register read request from the two-wire command decoder
    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
    } rd_req_s;

    // register read answer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rd_rsp_s;

endpackage

// >>> core/alarm_hyst_cmp.sv
// one channel's limit comparator with hysteresis release
// assumes reading, limit and hysteresis are stable in the update cycle
`timescale 1ns/1ns
module alarm_hyst_cmp #(
    parameter int TEMP_W = 11
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // comparison inputs
    input  wire logic              update,
    input  wire logic signed [TEMP_W-1:0] reading,
    input  wire logic signed [TEMP_W-1:0] limit,
    input  wire logic [TEMP_W-1:0] hyst,
    // result
    output logic                   flag
);
    // two extra bits: the most negative limit minus the largest hysteresis
    // still fits, so the release level never wraps to a high value
    logic signed [TEMP_W+1:0] release_lvl;
    logic                     at_limit;
    logic                     below_release;

    assign release_lvl   = $signed({{2{limit[TEMP_W-1]}}, limit}) - $signed({2'b00, hyst});
    assign at_limit      = reading >= limit;
    assign below_release = $signed({{2{reading[TEMP_W-1]}}, reading}) < release_lvl;

    // only a stored conversion moves the flag; in between it holds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (update) begin
            if (at_limit) begin
                flag <= 1'b1;
            end else if (below_release) begin
                flag <= 1'b0;
            end
        end
    end
endmodule

// >>> core/status_read_port.sv
// register read port for the three read-only status registers
// assumes the two-wire slave has already decoded the command byte
`timescale 1ns/1ns
module status_read_port
    import thermal_alarm_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // register contents
    input  wire logic [7:0] second_alarm_status,
    input  wire logic [7:0] third_alarm_status,
    input  wire logic [7:0] sensor_model_status,
    // request and answer
    input  wire rd_req_s    rd_req,
    output rd_rsp_s         rd_rsp
);
    logic       hit_second;
    logic       hit_third;
    logic       hit_model;
    logic [7:0] sel_data;

    // address decode; unmapped commands read as zero
    assign hit_second = rd_req.cmd == SECOND_ALARM_STATUS_OFS;
    assign hit_third  = rd_req.cmd == THIRD_ALARM_STATUS_OFS;
    assign hit_model  = rd_req.cmd == SENSOR_MODEL_STATUS_OFS;
    assign sel_data   = hit_second ? second_alarm_status :
                        hit_third  ? third_alarm_status  :
                        hit_model  ? sensor_model_status : UNMAPPED_RD;

    // answer one cycle after the request, data held until the next one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_rsp <= '0;
        end else begin
            rd_rsp.valid <= rd_req.valid;
            if (rd_req.valid) begin
                rd_rsp.data <= sel_data;
            end
        end
    end
endmodule

// >>> test/thermal_alarm_status_chk.sv
// checker for alarm pins, summary flags and read answers
// assumes one clock; bound onto thermal_alarm_status below
`timescale 1ns/1ns
module thermal_alarm_status_chk
    import thermal_alarm_pkg::*;
#(
    parameter int TEMP_W = 11
) (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // inputs of the block
    input wire ch_flags_s                result_stored,
    input wire logic signed [TEMP_W-1:0] local_reading,
    input wire logic signed [TEMP_W-1:0] local_limit,
    input wire ch_flags_s                mask_b,
    input wire logic [3:0]               beta_comp_on,
    input wire logic [3:0]               small_bjt_seen,
    input wire rd_req_s                  rd_req,
    // outputs of the block
    input wire rd_rsp_s                  rd_rsp,
    input wire logic                     alarm_b_summary_flag,
    input wire logic                     alarm_c_summary_flag,
    input wire logic                     second_alarm_out_n,
    input wire logic                     third_alarm_out_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // reads answer one cycle later, reserved bits low
    rsp_next_a: assert property (rd_req.valid |=> rd_rsp.valid)
        else $error("read answer missing");
    rsv_zero_a: assert property (rd_rsp.valid |-> rd_rsp.data[7:5] == 3'h0)
        else $error("reserved bits set");
    // model status lags its inputs by one register stage
    model_read_a: assert property (rd_req.valid && rd_req.cmd == 8'h38 |=>
        rd_rsp.data == {3'h0, $past(beta_comp_on, 2) & $past(small_bjt_seen, 2), 1'b0})
        else $error("model status wrong");
    // a reading at or above its limit shows two edges after its store
    set_sum_a: assert property (result_stored.local_ch && local_reading >= local_limit
        |-> ##2 alarm_b_summary_flag && alarm_c_summary_flag)
        else $error("summary not raised");
    // the pin register samples the mask one edge after the store
    set_pin_a: assert property (result_stored.local_ch && local_reading >= local_limit
        ##1 !mask_b.local_ch |=> !second_alarm_out_n)
        else $error("second pin not driven");
    rel_b_a: assert property (!alarm_b_summary_flag |-> second_alarm_out_n)
        else $error("second pin active with clear status");
    rel_c_a: assert property (!alarm_c_summary_flag |-> third_alarm_out_n)
        else $error("third pin active with clear status");
    // without stores the status cannot move
    hold_sum_a: assert property ((result_stored == 5'h00)[*2] |=>
        $stable(alarm_b_summary_flag) && $stable(alarm_c_summary_flag))
        else $error("summary moved without store");
endmodule

bind thermal_alarm_status thermal_alarm_status_chk #(.TEMP_W(TEMP_W)) chk_inst (
    .clk, .rst_n, .result_stored, .local_reading, .local_limit, .mask_b,
    .beta_comp_on, .small_bjt_seen, .rd_req, .rd_rsp, .alarm_b_summary_flag,
    .alarm_c_summary_flag, .second_alarm_out_n, .third_alarm_out_n
);

// >>> test/status_host.sv
// host model issuing single-byte status reads on the decoded command port
// assumes the block answers on the same edge that takes the request
`timescale 1ns/1ns
module status_host
    import thermal_alarm_pkg::*;
(
    // clock
    input wire logic clk,
    // read port
    output rd_req_s      rd_req,
    input wire rd_rsp_s  rd_rsp
);
    initial rd_req = '0;

    // request stands for exactly one taking edge; answer taken after it
    task automatic read(input logic [7:0] cmd, output rd_rsp_s rsp);
        @(negedge clk);
        rd_req = {1'b1, cmd};
        @(negedge clk);
        rd_req = '0;
        rsp = rd_rsp;
    endtask
endmodule

// >>> test/tb_thermal_alarm_status.sv
// self-checking bench for the second and third alarm status block
// assumes status_host as reader and the bound checker
`timescale 1ns/1ns
module tb_thermal_alarm_status
    import thermal_alarm_pkg::*;
;
    logic               clk            = 1'b0;
    logic               rst_n          = 1'b0;
    ch_flags_s          result_stored  = '0;
    ch_flags_s          mask_b         = '0;
    ch_flags_s          mask_c         = '0;
    logic [10:0]        shared_hyst    = 11'h005;
    logic [3:0]         beta_comp_on   = 4'h0;
    logic [3:0]         small_bjt_seen = 4'h0;
    logic signed [10:0] rdg [5]        = '{default: 11'h000};
    logic signed [10:0] lim [5]        = '{11'h064, 11'h05a, 11'h050, 11'h046, 11'h03c};
    rd_req_s            rd_req;
    rd_rsp_s            rd_rsp;
    rd_rsp_s            rsp;
    logic [3:0]         outs;
    int                 fail_count     = 0;
    int                 n_compared     = 0;

    thermal_alarm_status #(.TEMP_W(11)) thermal_alarm_status_inst (
        .clk, .rst_n, .result_stored, .mask_b, .mask_c, .shared_hyst,
        .local_reading(rdg[0]), .ch1_reading(rdg[1]), .ch2_reading(rdg[2]),
        .ch3_reading(rdg[3]), .ch4_reading(rdg[4]), .local_limit(lim[0]),
        .ch1_limit_b(lim[1]), .ch2_limit_b(lim[2]), .ch3_limit(lim[3]),
        .ch4_limit(lim[4]), .beta_comp_on, .small_bjt_seen, .rd_req, .rd_rsp,
        .alarm_b_summary_flag(outs[3]), .alarm_c_summary_flag(outs[2]),
        .second_alarm_out_n(outs[1]), .third_alarm_out_n(outs[0])
    );
    status_host status_host_inst (.clk, .rd_req, .rd_rsp);

    always #5 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one read, answer valid and data compared
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        status_host_inst.read(cmd, rsp);
        check({7'h00, rsp.valid}, 8'h01);
        check(rsp.data, exp);
    endtask

    // strobe, then let flag and pins settle two edges later
    task automatic store(input ch_flags_s m);
        @(negedge clk);
        result_stored = m;
        @(negedge clk);
        result_stored = '0;
        repeat (2) @(negedge clk);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h09, 8'h00);
        rd(8'h38, 8'h00);
        rd(8'h0b, 8'h00);
        check({4'h0, outs}, 8'h03);
        // one below each own limit: nothing sets, so no channel borrows a lower limit
        foreach (rdg[i]) rdg[i] = lim[i] - 11'h001;
        store(5'h1f);
        rd(8'h0a, 8'h00);
        for (int i = 0; i < 5; i++) begin
            rdg[i] = lim[i];
            store(ch_flags_s'(5'h01 << i));
            rd(8'h09, (8'h02 << i) - 8'h01);
            rd(8'h0a, (8'h02 << i) - 8'h01);
            check({4'h0, outs}, 8'h0c);
        end
        mask_b = 5'h1f;
        repeat (2) @(negedge clk);
        check({4'h0, outs}, 8'h0e);
        mask_c = 5'h1f;
        mask_b = 5'h1e;
        repeat (2) @(negedge clk);
        check({4'h0, outs}, 8'h0d);
        mask_c = 5'h00;
        for (int i = 1; i < 5; i++) rdg[i] = lim[i] - 11'h010;
        store(5'h1e);
        rd(8'h09, 8'h01);
        rdg[0] = lim[0] - 11'h005;
        store(5'h01);
        rd(8'h0a, 8'h01);
        rdg[0] = lim[0] - 11'h006;
        store(5'h01);
        rd(8'h09, 8'h00);
        check({4'h0, outs}, 8'h03);
        rdg[0] = lim[0];
        repeat (3) @(negedge clk);
        rd(8'h09, 8'h00);
        beta_comp_on = 4'hb;
        small_bjt_seen = 4'h6;
        rd(8'h38, 8'h04);
        small_bjt_seen = 4'hf;
        beta_comp_on = 4'hf;
        rd(8'h38, 8'h1e);
        // a reset in mid-run drops a set flag and releases both pins
        store(5'h01);
        check({4'h0, outs}, 8'h0c);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        check({4'h0, outs}, 8'h03);
        rd(8'h0a, 8'h00);
        tally_and_finish;
    end

    // cuts a hang short
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
endmodule
